// >>> buffered_pwm_compare_channels.sv
/*
 * eight buffered 16-bit compare channels on timer 2 or the compare timer,
 * with overflow-synchronised loading on the compare timer, plus the port 5 concurrent compare.
 * assumes the cpu writes come as one-cycle strobes synchronous to i_core_clk;
 * i_core_clk is the oscillator.
 */
// Behaviour
// - compare-timer channel: compare latch loads from register latch only at overflow.
// - every compare timer overflow sets the overflow flag.
// - overflow transfer happens only after a low-byte write since last transfer.
// - high-byte write alone never arms the transfer.
// - low-only write transfers new low byte with held high byte.
// - low-byte write arms a full 16-bit transfer; write high first.
// - select 0: low-byte write moves register latch straight to compare latch.
// - after reset all select bits are 0.
// - reload write starts the compare timer from the written value.
// - timer 2 channels run compare mode 1 like other timer 2 compares.
// - no per-channel interrupt; buffering gives consistent 16-bit loads.
// - in mode 2 the set and clear registers drive port 5.
// - set and clear matches raise their own separate flags.
// - a flag stays set while its match condition persists.
// - mode 0 reaches full 100 percent duty swing only when compare value equals reload value.
// - timer 2 mode 0 spike splits at reload value and at FFFF.
// - timer 2 advances once every 12 oscillator periods.
// - select 1 binds compare timer mode 0; select 0 timer 2 mode 1.
// - enable bit activates compare and drives the port 4 line.
`timescale 1ns/1ps
`include "pwm_compare_consts.svh"

module buffered_pwm_compare_channels #(
	parameter int CT_PRESCALE = 2
) (
	// clock and reset
	input  wire logic                          i_core_clk,
	input  wire logic                          i_rst_n,
	// channel writes
	input  pwm_compare_pkg::chan_write_t       i_chan_write,
	input  wire logic [`CH_COUNT-1:0]          i_timebase_select,
	input  wire logic [`CH_COUNT-1:0]          i_channel_output_enable,
	// compare timer
	input  wire logic                          i_ctimer_reload_we,
	input  wire logic [`CNT_WIDTH-1:0]         i_ctimer_reload,
	input  wire logic                          i_ctimer_flag_clr,
	// timer 2 (mode 1 level written by cpu per channel)
	input  wire logic [`CNT_WIDTH-1:0]         i_t2_reload,
	input  wire logic [`CH_COUNT-1:0]          i_mode1_level,
	// port 4 latch writes
	input  wire logic                          i_port4_we,
	input  wire logic [`CH_COUNT-1:0]          i_port4_data,
	// concurrent compare
	input  pwm_compare_pkg::concur_cfg_t       i_concur_cfg,
	input  wire logic                          i_set_flag_clr,
	input  wire logic                          i_clear_flag_clr,
	// outputs
	output logic [`CH_COUNT-1:0]               o_pwm_port_pin,
	output logic                               o_ctimer_overflow_flag,
	output logic [`CNT_WIDTH-1:0]              o_ctimer_count,
	output logic [`CNT_WIDTH-1:0]              o_t2_count,
	output logic [`CONCUR_COUNT-1:0]           o_port5,
	output logic                               o_set_match_flag,
	output logic                               o_clear_match_flag
);
	import pwm_compare_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [`CH_COUNT-1:0][`CNT_WIDTH-1:0] reg_latch;
		logic [`CH_COUNT-1:0][`CNT_WIDTH-1:0] cmp_latch;
		logic [`CH_COUNT-1:0]                 armed;
		logic [`CH_COUNT-1:0]                 out;
		ctimer_state_t                        ct_state;
		logic [`CNT_WIDTH-1:0]                ct_count;
		logic [`CNT_WIDTH-1:0]                ct_reload;
		logic                                 ct_flag;
		logic [`CNT_WIDTH-1:0]                t2_count;
	} core_state_t;

	core_state_t st;
	core_state_t next_st;
	logic        t2_tick;
	logic        ct_tick;
	logic        ct_ovf;
	logic        t2_ovf;
	logic        p5_set_flag;
	logic        p5_clear_flag;
	logic [`CONCUR_COUNT-1:0] p5_pins;

	function automatic logic hit(input logic [`CNT_WIDTH-1:0] a, input logic [`CNT_WIDTH-1:0] b);
		hit = (a == b);
	endfunction : hit

	// ----------------------------------------
	// timer clocks
	// ----------------------------------------
	// one tick per 12 oscillator periods
	tick_divider #(.DIV(`OSC_PER_T2_TICK)) u_t2_div (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.o_tick     (t2_tick)
	);

	tick_divider #(.DIV(CT_PRESCALE)) u_ct_div (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.o_tick     (ct_tick)
	);

	concurrent_compare u_concur (
		.i_core_clk         (i_core_clk),
		.i_rst_n            (i_rst_n),
		.i_tick             (t2_tick),
		.i_count            (st.t2_count),
		.i_cfg              (i_concur_cfg),
		.i_set_flag_clr     (i_set_flag_clr),
		.i_clear_flag_clr   (i_clear_flag_clr),
		.o_port5            (p5_pins),
		.o_set_match_flag   (p5_set_flag),
		.o_clear_match_flag (p5_clear_flag)
	);

	assign ct_ovf = ct_tick && (st.ct_state == CT_RUN) && hit(st.ct_count, `CNT_MAX);
	assign t2_ovf = t2_tick && hit(st.t2_count, `CNT_MAX);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;

		// timer 2 auto-reload
		if (t2_tick) begin
			next_st.t2_count = t2_ovf ? i_t2_reload : st.t2_count + 16'h0001;
		end

		if (i_ctimer_reload_we) begin
			next_st.ct_reload = i_ctimer_reload;
			next_st.ct_count  = i_ctimer_reload;
			next_st.ct_state  = CT_RUN;
		end else if (ct_tick && st.ct_state == CT_RUN) begin
			next_st.ct_count = ct_ovf ? st.ct_reload : st.ct_count + 16'h0001;
		end

		// overflow sets flag; set wins over clear
		if (ct_ovf) begin
			next_st.ct_flag = 1'b1;
		end else if (i_ctimer_flag_clr) begin
			next_st.ct_flag = 1'b0;
		end

		for (int i = 0; i < `CH_COUNT; i++) begin
			// full register latch moves, high byte kept
			if (i_timebase_select[i] && ct_ovf && st.armed[i]) begin
				next_st.cmp_latch[i] = st.reg_latch[i];
				next_st.armed[i]     = 1'b0;
			end
			// high byte alone does not arm
			if (i_chan_write.high_we && i_chan_write.ch == 3'(i)) begin
				next_st.reg_latch[i][15:8] = i_chan_write.data;
			end
			if (i_chan_write.low_we && i_chan_write.ch == 3'(i)) begin
				next_st.reg_latch[i][7:0] = i_chan_write.data;
				// mode 1 low write loads directly
				if (i_timebase_select[i]) begin
					next_st.armed[i] = 1'b1;
				end else begin
					next_st.cmp_latch[i] = {st.reg_latch[i][15:8], i_chan_write.data};
				end
			end

			if (i_channel_output_enable[i]) begin
				if (i_timebase_select[i]) begin
					// high on match, low on overflow
					// overflow drives the output low until the next match unless the compare latch equals the reload value
					if (ct_ovf) begin
						next_st.out[i] = hit(st.cmp_latch[i], st.ct_reload);
					end else if (ct_tick && hit(st.ct_count, st.cmp_latch[i])) begin
						next_st.out[i] = 1'b1;
					end
				end else if (t2_tick && hit(st.t2_count, st.cmp_latch[i])) begin
					next_st.out[i] = i_mode1_level[i];
				end
			end
			if (i_port4_we && !(i_channel_output_enable[i] && t2_tick)) begin
				next_st.out[i] = i_port4_data[i];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st                     <= '0;
			o_pwm_port_pin         <= '0;
			o_ctimer_overflow_flag <= 1'b0;
			o_ctimer_count         <= `CNT_RESET;
			o_t2_count             <= `CNT_RESET;
			o_port5                <= '0;
			o_set_match_flag       <= 1'b0;
			o_clear_match_flag     <= 1'b0;
		end else begin
			st                     <= next_st;
			o_pwm_port_pin         <= next_st.out;
			o_ctimer_overflow_flag <= next_st.ct_flag;
			o_ctimer_count         <= next_st.ct_count;
			o_t2_count             <= next_st.t2_count;
			o_port5                <= p5_pins;
			o_set_match_flag       <= p5_set_flag;
			o_clear_match_flag     <= p5_clear_flag;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// select resets to zero: selects are ports, reset value documented as 8'h00
	// timer 2 spike halves come from reload and FFFF compare in the wider timer 2 unit

	property p_ovf_flag;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		ct_ovf |=> st.ct_flag ##1 o_ctimer_overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");

	property p_no_direct_load;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_timebase_select[1] && $past(i_timebase_select[1]) && !ct_ovf && !$past(ct_ovf))
			|-> $stable(st.cmp_latch[1]);
	endproperty
	a_no_direct_load: assert property (p_no_direct_load) else $error("compare latch loaded off overflow");

	property p_unarmed;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(ct_ovf && i_timebase_select[1] && !st.armed[1] && !(i_chan_write.low_we && i_chan_write.ch == 3'd1))
			|=> $stable(st.cmp_latch[1]);
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("transfer without low-byte write");

	property p_high_no_arm;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_chan_write.high_we && !i_chan_write.low_we && i_chan_write.ch == 3'd1 && !st.armed[1])
			|=> !st.armed[1];
	endproperty
	a_high_no_arm: assert property (p_high_no_arm) else $error("high byte armed transfer");

	property p_armed_xfer;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(ct_ovf && i_timebase_select[1] && st.armed[1] && !i_chan_write.high_we && !i_chan_write.low_we)
			|=> (st.cmp_latch[1] == $past(st.reg_latch[1])) && !st.armed[1];
	endproperty
	a_armed_xfer: assert property (p_armed_xfer) else $error("armed 16-bit transfer lost");

	property p_mode1_direct;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_chan_write.low_we && i_chan_write.ch == 3'd0 && !i_timebase_select[0] && !i_chan_write.high_we)
			|=> st.cmp_latch[0] == {$past(st.reg_latch[0][15:8]), $past(i_chan_write.data)};
	endproperty
	a_mode1_direct: assert property (p_mode1_direct) else $error("mode 1 low write not direct");

	property p_reload_start;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_ctimer_reload_we |=> (st.ct_count == $past(i_ctimer_reload)) && (st.ct_state == CT_RUN);
	endproperty
	a_reload_start: assert property (p_reload_start) else $error("reload write did not start timer");

	property p_t2_rate;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		t2_tick |=> !t2_tick [*8];
	endproperty
	a_t2_rate: assert property (p_t2_rate) else $error("timer 2 ticked too fast");

	property p_ovf_low;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(ct_ovf && i_channel_output_enable[1] && i_timebase_select[1] && !i_port4_we
			&& st.cmp_latch[1] != st.ct_reload) |=> !st.out[1];
	endproperty
	a_ovf_low: assert property (p_ovf_low) else $error("mode 0 output not low after overflow");

	c_overflow:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) ct_ovf && st.armed[1]);
	c_mode1:     cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_chan_write.low_we && !i_timebase_select[i_chan_write.ch]);
	c_pwm_high:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(o_pwm_port_pin[0]));

endmodule : buffered_pwm_compare_channels

// >>> pwm_compare_consts.svh
/*
 * constants of the buffered compare channel block: widths, reset values, timer rates.
 * assumes inclusion by the package and the modules; definitions only.
 */
`ifndef PWM_COMPARE_CONSTS_SVH
`define PWM_COMPARE_CONSTS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define CH_COUNT         8
`define CNT_WIDTH        16
`define CONCUR_COUNT     8

// ----------------------------------------
// reset values
// ----------------------------------------
`define SEL_RESET        8'h00
`define EN_RESET         8'h00
`define CNT_RESET        16'h0000
`define CNT_MAX          16'hFFFF

// ----------------------------------------
// timing: timer 2 advances once per 12 oscillator periods
// ----------------------------------------
`define OSC_PER_T2_TICK  12
`define T2_DIV_WIDTH     4

`endif

// >>> pwm_compare_pkg.sv
/*
 * types shared by the buffered compare channel block.
 * assumes pwm_compare_consts.svh is on the include path.
 */
`include "pwm_compare_consts.svh"

package pwm_compare_pkg;

	// ----------------------------------------
	// software write strobes for one channel
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] ch;
		logic       low_we;
		logic       high_we;
		logic [7:0] data;
	} chan_write_t;

	// ----------------------------------------
	// concurrent compare (port 5) controls
	// ----------------------------------------
	typedef struct packed {
		logic                      mode2;
		logic                      set_en;
		logic                      clear_en;
		logic [`CNT_WIDTH-1:0]     set_value;
		logic [`CNT_WIDTH-1:0]     clear_value;
		logic [`CONCUR_COUNT-1:0]  cc4_pins;
		logic [`CONCUR_COUNT-1:0]  gpio_pins;
		logic [`CONCUR_COUNT-1:0]  set_mask;
		logic [`CONCUR_COUNT-1:0]  clear_mask;
	} concur_cfg_t;

	typedef enum logic [1:0] {
		CT_IDLE = 2'b00,
		CT_RUN  = 2'b01
	} ctimer_state_t;

endpackage : pwm_compare_pkg

// >>> tick_divider.sv
/*
 * divider producing a one-cycle enable every DIV clocks.
 * assumes a single clock domain and a free running divider.
 */
`timescale 1ns/1ps
`include "pwm_compare_consts.svh"

module tick_divider #(
	parameter int DIV = 2
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	// enable out
	output logic      o_tick
);
	import pwm_compare_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 8'(DIV - 1)) begin
			next_st.cnt  = 8'h00;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_tick = st.tick;

endmodule : tick_divider

// >>> concurrent_compare.sv
/*
 * concurrent set/clear compare of port 5 with sticky match flags.
 * assumes timer 2 count and its tick arrive from the main module.
 */
`timescale 1ns/1ps
`include "pwm_compare_consts.svh"

module concurrent_compare (
	// clock and reset
	input  wire logic                            i_core_clk,
	input  wire logic                            i_rst_n,
	// timebase and config
	input  wire logic                            i_tick,
	input  wire logic [`CNT_WIDTH-1:0]           i_count,
	input  pwm_compare_pkg::concur_cfg_t         i_cfg,
	input  wire logic                            i_set_flag_clr,
	input  wire logic                            i_clear_flag_clr,
	// results
	output logic [`CONCUR_COUNT-1:0]             o_port5,
	output logic                                 o_set_match_flag,
	output logic                                 o_clear_match_flag
);
	import pwm_compare_pkg::*;

	typedef struct packed {
		logic [`CONCUR_COUNT-1:0] latch;
		logic                     set_flag;
		logic                     clear_flag;
	} cc_state_t;

	cc_state_t st;
	cc_state_t next_st;
	logic      set_hit;
	logic      clear_hit;

	always_comb begin
		set_hit   = i_cfg.set_en && (i_count == i_cfg.set_value);
		clear_hit = i_cfg.clear_en && (i_count == i_cfg.clear_value);
		next_st = st;
		if (set_hit) begin
			next_st.set_flag = 1'b1;
		end else if (i_set_flag_clr) begin
			next_st.set_flag = 1'b0;
		end
		if (clear_hit) begin
			next_st.clear_flag = 1'b1;
		end else if (i_clear_flag_clr) begin
			next_st.clear_flag = 1'b0;
		end
		if (i_tick && set_hit) begin
			next_st.latch = st.latch | i_cfg.set_mask;
		end
		if (i_tick && clear_hit) begin
			next_st.latch = next_st.latch & ~i_cfg.clear_mask;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st      <= '0;
			o_port5 <= '0;
		end else begin
			st <= next_st;
			o_port5 <= i_cfg.mode2 ? next_st.latch : (i_cfg.gpio_pins | i_cfg.cc4_pins);
		end
	end

	assign o_set_match_flag   = st.set_flag;
	assign o_clear_match_flag = st.clear_flag;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_set_hold;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		set_hit |=> o_set_match_flag;
	endproperty
	a_set_hold: assert property (p_set_hold) else $error("set match flag not held");

	property p_clear_sep;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(clear_hit && !set_hit && !o_set_match_flag) |=> (o_clear_match_flag && !o_set_match_flag);
	endproperty
	a_clear_sep: assert property (p_clear_sep) else $error("clear match raised wrong flag");

	property p_mode2_port;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_cfg.mode2 |=> (o_port5 == st.latch) || !$past(i_cfg.mode2);
	endproperty
	a_mode2_port: assert property (p_mode2_port) else $error("port 5 not driven by concurrent latch");

endmodule : concurrent_compare

// >>> cpu_sfr_model.sv
/*
 * partner model: the processor core writing channel bytes, one strobe per cycle.
 * assumes one clock shared with the compare block; requests come from the bench.
 */
`timescale 1ns/1ps
`include "pwm_compare_consts.svh"

module cpu_sfr_model (
	// clock and reset
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_n,
	// bench request
	input  wire logic                    i_start,
	input  wire logic [2:0]              i_ch,
	input  wire logic [15:0]             i_value,
	input  wire logic                    i_high,
	input  wire logic                    i_low,
	// towards the block
	output pwm_compare_pkg::chan_write_t o_chan_write,
	output logic                         o_busy
);
	import pwm_compare_pkg::*;

	logic        pend_high;
	logic        pend_low;
	logic [15:0] value;

	assign o_busy = pend_high | pend_low;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_chan_write <= '0;
			pend_high    <= 1'b0;
			pend_low     <= 1'b0;
			value        <= '0;
		end else begin
			if (i_start) begin
				o_chan_write.low_we  <= 1'b0;
				o_chan_write.high_we <= 1'b0;
				o_chan_write.data    <= ~o_chan_write.data;
				pend_high            <= i_high;
				pend_low             <= i_low;
				value                <= i_value;
				o_chan_write.ch      <= i_ch;
			end else if (pend_high) begin
				o_chan_write.low_we  <= 1'b0;
				o_chan_write.high_we <= 1'b1;
				o_chan_write.data    <= value[15:8];
				pend_high            <= 1'b0;
			end else if (pend_low) begin
				o_chan_write.low_we  <= 1'b1;
				o_chan_write.high_we <= 1'b0;
				o_chan_write.data    <= value[7:0];
				pend_low             <= 1'b0;
			end else begin
				// idle data toggles, a stale byte must not look valid
				o_chan_write.low_we  <= 1'b0;
				o_chan_write.high_we <= 1'b0;
				o_chan_write.data    <= ~o_chan_write.data;
			end
		end
	end

endmodule : cpu_sfr_model

// >>> buffered_pwm_compare_channels_tb.sv
/*
 * self-checking bench for the buffered compare channels.
 * assumes the design files and cpu_sfr_model are compiled first.
 */
`timescale 1ns/1ps
`include "pwm_compare_consts.svh"

module buffered_pwm_compare_channels_tb;
	import pwm_compare_pkg::*;

	localparam int CT_PRE = 2;
	logic        clk, rst_n, w_start, w_high, w_low, w_busy, rl_we, fl_clr, p4_we, s_clr, c_clr;
	logic [2:0]  w_ch;
	logic [15:0] w_val, rl_val, t2_cnt, ct_cnt, t0;
	logic [7:0]  sel, en, lvl, p4_data, pin, port5;
	logic        ovf_flag, s_flag, c_flag, seen;
	chan_write_t cw;
	concur_cfg_t cfg;
	int          fail_count, total_checks, hi, cyc;

	// ----------------------------------------
	// clock, partner and device
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	cpu_sfr_model cpu_sfr_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(w_start), .i_ch(w_ch),
		.i_value(w_val), .i_high(w_high), .i_low(w_low), .o_chan_write(cw), .o_busy(w_busy));

	buffered_pwm_compare_channels #(.CT_PRESCALE(CT_PRE)) buffered_pwm_compare_channels_i (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_chan_write(cw), .i_timebase_select(sel),
		.i_channel_output_enable(en), .i_ctimer_reload_we(rl_we), .i_ctimer_reload(rl_val),
		.i_ctimer_flag_clr(fl_clr), .i_t2_reload(16'h0000), .i_mode1_level(lvl), .i_port4_we(p4_we),
		.i_port4_data(p4_data), .i_concur_cfg(cfg), .i_set_flag_clr(s_clr), .i_clear_flag_clr(c_clr),
		.o_pwm_port_pin(pin), .o_ctimer_overflow_flag(ovf_flag), .o_ctimer_count(ct_cnt),
		.o_t2_count(t2_cnt), .o_port5(port5), .o_set_match_flag(s_flag), .o_clear_match_flag(c_flag));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask : check

	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc_wait

	task automatic cpu_write(input logic [2:0] ch, input logic [15:0] v, input logic h, input logic l);
		int n;
		@(posedge clk);
		w_start <= 1'b1;
		w_ch    <= ch;
		w_val   <= v;
		w_high  <= h;
		w_low   <= l;
		@(posedge clk);
		w_start <= 1'b0;
		n = 0;
		do begin
			cyc_wait(1);
			n++;
		end while (w_busy !== 1'b0 && n < 10);
		if (n >= 10) begin
			fail_count++;
			wrap_up();
		end
		cyc_wait(1);
	endtask : cpu_write

	// waits for the next overflow flag, counting high cycles of pin 1, then clears it
	task automatic wait_ovf;
		hi  = 0;
		cyc = 0;
		while (cyc < 200) begin
			cyc_wait(1);
			cyc++;
			if (pin[1] === 1'b1)
				hi++;
			if (ovf_flag === 1'b1)
				break;
		end
		if (cyc >= 200) begin
			fail_count++;
			wrap_up();
		end
		@(posedge clk);
		fl_clr <= 1'b1;
		@(posedge clk);
		fl_clr <= 1'b0;
		cyc_wait(2);
	endtask : wait_ovf

	// high time of a compare-timer period for compare value c, reload 16'hFFF0
	task automatic check_duty(input logic [15:0] c);
		int e;
		e = (c >= 16'hFFF0) ? 2 * (32'hFFFF - int'(c)) + 1 : 0;
		check(16'((hi >= e - (e ? 2 : 0)) && (hi <= e + (e ? 2 : 0))), 16'h0001);
	endtask : check_duty

	// which 0 watches pin 0, otherwise the set match flag
	task automatic await_bit(input int which, input int lim);
		int n;
		n = 0;
		while (((which == 0) ? pin[0] : s_flag) !== 1'b1 && n < lim) begin
			cyc_wait(1);
			n++;
		end
		check(16'((which == 0) ? pin[0] : s_flag), 16'h0001);
	endtask : await_bit

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		fail_count = 0;
		total_checks = 0;
		rst_n = 1'b0;
		{w_start, w_high, w_low, rl_we, fl_clr, p4_we, s_clr, c_clr} = '0;
		w_ch = '0;
		w_val = '0;
		rl_val = '0;
		{sel, en, lvl, p4_data} = '0;
		cfg = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		cyc_wait(1);
		check(16'(pin), 16'h0000);
		check(16'(ovf_flag), 16'h0000);
		// ---- timer 2 rate ----
		t0 = t2_cnt;
		cyc_wait(12);
		check(t2_cnt - t0, 16'h0001);
		cyc_wait(24);
		check(t2_cnt - t0, 16'h0003);
		// ---- channel 0 on timer 2, direct load ----
		@(posedge clk);
		en  <= 8'h01;
		lvl <= 8'h01;
		cyc_wait(1);
		cpu_write(3'd0, t2_cnt + 16'h0004, 1'b1, 1'b1);
		check(16'(pin[0]), 16'h0000);
		await_bit(0, 80);
		check(16'(pin[7:2]), 16'h0000);
		// ---- channel 1 preload, then compare timer ----
		// documented setup order
		cpu_write(3'd1, 16'hFFF4, 1'b1, 1'b1);
		@(posedge clk);
		sel <= 8'h02;
		cpu_write(3'd1, 16'hFFFC, 1'b1, 1'b1);
		@(posedge clk);
		en      <= 8'h03;
		p4_we   <= 1'b1;
		p4_data <= 8'h00;
		@(posedge clk);
		p4_we   <= 1'b0;
		rl_we   <= 1'b1;
		rl_val  <= 16'hFFF0;
		@(posedge clk);
		rl_we   <= 1'b0;
		wait_ovf();
		check_duty(16'hFFF4);
		wait_ovf();
		check_duty(16'hFFFC);
		check(16'(cyc + 4), 16'(16 * CT_PRE));
		cpu_write(3'd1, 16'h0000, 1'b1, 1'b0);
		wait_ovf();
		check_duty(16'hFFFC);
		wait_ovf();
		check_duty(16'hFFFC);
		cpu_write(3'd1, 16'h77F8, 1'b0, 1'b1);
		wait_ovf();
		check_duty(16'hFFFC);
		wait_ovf();
		check_duty(16'h00F8);
		cpu_write(3'd1, 16'hFFF8, 1'b1, 1'b1);
		wait_ovf();
		check_duty(16'h00F8);
		wait_ovf();
		check_duty(16'hFFF8);
		// ---- port 5 concurrent compare ----
		@(posedge clk);
		cfg.gpio_pins <= 8'h0F;
		cfg.cc4_pins  <= 8'h30;
		cyc_wait(3);
		check(16'(port5), 16'h003F);
		@(posedge clk);
		cfg.mode2       <= 1'b1;
		cfg.set_en      <= 1'b1;
		cfg.clear_en    <= 1'b1;
		cfg.set_mask    <= 8'hA5;
		cfg.clear_mask  <= 8'h5A;
		cfg.set_value   <= t2_cnt + 16'h0002;
		cfg.clear_value <= t2_cnt - 16'h0001;
		await_bit(1, 60);
		@(posedge clk);
		s_clr <= 1'b1;
		@(posedge clk);
		s_clr <= 1'b0;
		cyc_wait(2);
		check(16'(s_flag), 16'h0001);
		check(16'(c_flag), 16'h0000);
		cyc_wait(14);
		check(16'(port5 & 8'hA5), 16'h00A5);
		@(posedge clk);
		s_clr <= 1'b1;
		@(posedge clk);
		s_clr <= 1'b0;
		cyc_wait(3);
		check(16'(s_flag), 16'h0000);
		wrap_up();
	end

endmodule : buffered_pwm_compare_channels_tb
